// file: async_request_ack_posting.sv
// Acknowledge choice, posted-write tracking, ordering and receive-context failure handling.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "async_request_ack_posting_map.svh"

module async_request_ack_posting
#(
   parameter int posted_slots = `POSTED_SLOTS
)
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB register port.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Incoming request header and its acknowledge.
   input wire logic req_valid,
   input wire async_request_ack_posting_pkg::request_type req,
   input wire logic req_fifo_full,
   output async_request_ack_posting_pkg::ack_type ack,
   // System side of the request receive FIFO.
   input wire logic desc_len_valid,
   input wire logic [13:0] request_buffer_length,
   input wire logic store_quadlet,
   input wire logic store_fail,
   // Heads of the two request queues.
   input wire logic arq_head_valid,
   output logic arq_head_go,
   output logic arq_head_drop,
   input wire logic phys_head_valid,
   output logic phys_head_go,
   // Memory completion of posted writes.
   input wire logic mem_done_valid,
   input wire logic [1:0] mem_done_slot,
   input wire logic mem_done_error,
   output logic posted_fail_event,
   // Transmit acknowledge and retry control.
   input wire logic tx_ack_valid,
   input wire logic [3:0] tx_ack_code,
   output logic tx_retry,
   output logic tx_give_up
);

   // Block state in one register, apart from the held request header and the posted records.
   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic context_running;
      logic post_enable;
      logic dual_retry;
      logic [3:0] retry_limit;
      logic [47:0] physical_range_limit;
      logic [14:0] space;
      logic dead;
      logic fail_sticky;
      logic [31:0] posted_fail_offset_low;
      logic [31:0] posted_fail_offset_high;
      async_request_ack_posting_pkg::ack_type ack;
      logic busy_phase;
      logic arq_go;
      logic arq_drop;
      logic phys_go;
      logic fail_event;
      logic [3:0] tx_count;
      logic tx_retry;
      logic tx_give_up;
   } state_type;

   state_type state;
   state_type next_state;

   async_request_ack_posting_pkg::record_type recs [posted_slots];
   logic [posted_slots-1:0] slot_alloc;
   logic [posted_slots-1:0] slot_done;
   logic free_found;
   logic [1:0] free_slot;
   logic [3:0] pending_count;
   logic phys_pending;
   logic defined_tcode;
   logic is_write;
   logic in_reg_space;
   logic ext_block;
   logic below_limit;
   logic in_upper;
   logic async_blocked;
   logic bus_write;
   logic [15:0] space_sum;
   logic [3:0] busy_code;
   async_request_ack_posting_pkg::record_type done_rec;
   logic [15:0] req_hold_node;
   logic [47:0] req_hold_offset;

   // Lowest free record, pending totals and the record that is completing.
   // A slot being filled this cycle counts as taken, so back-to-back posts never share it.
   always_comb
   begin
      free_found = 1'b0;
      free_slot = 2'h0;
      pending_count = 4'h0;
      phys_pending = 1'b0;
      for (int i = posted_slots - 1; i >= 0; i--)
      begin
         if (!recs[i].busy && !slot_alloc[i])
         begin
            free_found = 1'b1;
            free_slot = 2'(i);
         end
         pending_count = pending_count + {3'h0, recs[i].busy};
         phys_pending = phys_pending | (recs[i].busy & recs[i].physical);
      end
      done_rec = recs[mem_done_slot];
   end

   // Request classification; only request codes from the bus standard are accepted.
   assign defined_tcode = (req.tcode == `TC_WRITE_QUAD) || (req.tcode == `TC_WRITE_BLOCK) ||
      (req.tcode == `TC_READ_QUAD) || (req.tcode == `TC_READ_BLOCK) ||
      (req.tcode == `TC_LOCK) || (req.tcode == `TC_PHY);
   assign is_write = (req.tcode == `TC_WRITE_QUAD) || (req.tcode == `TC_WRITE_BLOCK);
   assign in_reg_space = req.offset >= `REG_SPACE_BASE;
   assign ext_block = (req.ext_tcode != 16'h0000) && ((req.tcode == `TC_WRITE_BLOCK) ||
      (req.tcode == `TC_READ_BLOCK) || (req.tcode == `TC_LOCK));
   assign below_limit = req.offset < state.physical_range_limit;
   assign in_upper = !below_limit && (req.offset <= `UPPER_TOP);
   assign async_blocked = state.dead || req_fifo_full ||
      ({1'b0, state.space} < {1'b0, req.quadlets});
   assign bus_write = psel && penable && pwrite && state.pready;
   assign busy_code = !state.dual_retry ? `ACK_BUSY_X :
      (state.busy_phase ? `ACK_BUSY_B : `ACK_BUSY_A);
   assign space_sum = {1'b0, state.space} +
      (desc_len_valid ? {2'h0, request_buffer_length} : 16'h0000) -
      (store_quadlet ? 16'h0001 : 16'h0000);

   // Record allocation and completion strobes, one per slot.
   always_comb
   begin
      for (int i = 0; i < posted_slots; i++)
      begin
         slot_alloc[i] = state.ack.posted && (state.ack.slot == 2'(i));
         slot_done[i] = mem_done_valid && (mem_done_slot == 2'(i));
      end
   end

   // One record per posted write that may be outstanding.
   generate
      for (genvar g = 0; g < posted_slots; g++)
      begin : gen_record
         posted_record u_record
         (
            .pclk(pclk),
            .presetn(presetn),
            .alloc(slot_alloc[g]),
            .alloc_physical(state.ack.dest == async_request_ack_posting_pkg::dest_physical),
            .alloc_node(req_hold_node),
            .alloc_offset(req_hold_offset),
            .done(slot_done[g]),
            .rec(recs[g])
         );
      end
   endgenerate

   // Header of the request just acknowledged, held for the record it allocates.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_hold_node <= 16'h0000;
         req_hold_offset <= 48'h0000_0000_0000;
      end
      else if (req_valid)
      begin
         req_hold_node <= req.source_id;
         req_hold_offset <= req.offset;
      end
   end

   // Next-state logic for the bus slave, the acknowledge and the queue gates.
   always_comb
   begin
      next_state = state;
      next_state.ack = '0;
      next_state.arq_go = 1'b0;
      next_state.arq_drop = 1'b0;
      next_state.phys_go = 1'b0;
      next_state.fail_event = 1'b0;
      next_state.tx_retry = 1'b0;
      next_state.tx_give_up = 1'b0;

      // APB: one wait state, then the write lands on the edge that samples pready.
      next_state.pready = psel && penable && !state.pready;
      next_state.pslverr = 1'b0;
      if (psel && penable && !state.pready)
      begin
         next_state.prdata = 32'h0000_0000;
         if (paddr == `REG_CONTROL)
         begin
            next_state.prdata[`CTRL_RUN_BIT] = state.context_running;
            next_state.prdata[`CTRL_POST_BIT] = state.post_enable;
            next_state.prdata[`CTRL_DUAL_BIT] = state.dual_retry;
            next_state.prdata[`CTRL_RETRY_LSB +: 4] = state.retry_limit;
         end
         else if (paddr == `REG_LIMIT_LOW)
         begin
            next_state.prdata = state.physical_range_limit[31:0];
         end
         else if (paddr == `REG_LIMIT_HIGH)
         begin
            next_state.prdata[15:0] = state.physical_range_limit[47:32];
         end
         else if (paddr == `REG_STATUS)
         begin
            next_state.prdata[`STAT_DEAD_BIT] = state.dead;
            next_state.prdata[`STAT_FAIL_BIT] = state.fail_sticky;
            next_state.prdata[`STAT_PEND_LSB +: 4] = pending_count;
            next_state.prdata[`STAT_SPACE_LSB +: 15] = state.space;
         end
         else if (paddr == `REG_FAIL_LOW)
         begin
            next_state.prdata = state.posted_fail_offset_low;
         end
         else if (paddr == `REG_FAIL_HIGH)
         begin
            next_state.prdata = state.posted_fail_offset_high;
         end
         else
         begin
            next_state.pslverr = 1'b1;
         end
      end
      if (bus_write)
      begin
         if (paddr == `REG_CONTROL)
         begin
            next_state.context_running = pwdata[`CTRL_RUN_BIT];
            next_state.post_enable = pwdata[`CTRL_POST_BIT];
            next_state.dual_retry = pwdata[`CTRL_DUAL_BIT];
            next_state.retry_limit = pwdata[`CTRL_RETRY_LSB +: 4];
         end
         else if (paddr == `REG_LIMIT_LOW)
         begin
            next_state.physical_range_limit[31:0] = pwdata;
         end
         else if (paddr == `REG_LIMIT_HIGH)
         begin
            next_state.physical_range_limit[47:32] = pwdata[15:0];
         end
         else if ((paddr == `REG_STATUS) && pwdata[`STAT_FAIL_BIT])
         begin
            next_state.fail_sticky = 1'b0;
         end
      end

      // Link-side space count; a store failure kills the context until it is stopped.
      if (!state.context_running)
      begin
         next_state.space = 15'h0000;
         next_state.dead = 1'b0;
      end
      else if (store_fail || state.dead)
      begin
         next_state.space = 15'h0000;
         next_state.dead = 1'b1;
      end
      else
      begin
         next_state.space = space_sum[14:0];
      end

      // Acknowledge choice, in falling priority.
      if (req_valid && defined_tcode)
      begin
         next_state.ack.valid = req.tcode != `TC_PHY;
         if (in_reg_space || ext_block)
         begin
            next_state.ack.code = `ACK_PENDING;
            next_state.ack.dest = async_request_ack_posting_pkg::dest_async;
         end
         else if (below_limit)
         begin
            next_state.ack.dest = async_request_ack_posting_pkg::dest_physical;
            next_state.ack.code = `ACK_PENDING;
            if (is_write && state.post_enable && free_found)
            begin
               next_state.ack.code = `ACK_COMPLETE;
               next_state.ack.posted = 1'b1;
               next_state.ack.slot = free_slot;
            end
         end
         else if (async_blocked)
         begin
            next_state.ack.code = busy_code;
            next_state.busy_phase = !state.busy_phase;
         end
         else if (in_upper && is_write)
         begin
            next_state.ack.dest = async_request_ack_posting_pkg::dest_async;
            next_state.ack.code = free_found ? `ACK_COMPLETE : busy_code;
            next_state.ack.posted = free_found;
            next_state.ack.slot = free_slot;
            next_state.busy_phase = state.busy_phase ^ !free_found;
         end
         else
         begin
            next_state.ack.code = `ACK_PENDING;
            next_state.ack.dest = async_request_ack_posting_pkg::dest_async;
         end
      end

      // Async queue head waits for physical posts; a dead context drains it instead.
      if (arq_head_valid && !state.arq_go && !state.arq_drop)
      begin
         if (state.dead)
         begin
            next_state.arq_drop = 1'b1;
         end
         else if (!phys_pending && !(state.ack.posted &&
            (state.ack.dest == async_request_ack_posting_pkg::dest_physical)))
         begin
            next_state.arq_go = 1'b1;
         end
      end

      // Physical queue leaves strictly in arrival order and ignores async posts.
      next_state.phys_go = phys_head_valid && !state.phys_go;

      // Failure capture; a new failure wins over a clear in the same cycle.
      if (mem_done_valid && mem_done_error && done_rec.busy)
      begin
         next_state.fail_sticky = 1'b1;
         next_state.fail_event = 1'b1;
         next_state.posted_fail_offset_low = done_rec.offset[31:0];
         next_state.posted_fail_offset_high = {done_rec.node_id, done_rec.offset[47:32]};
      end

      // Transmit retry without software; the count restarts on any settled ack.
      if (tx_ack_valid)
      begin
         if ((tx_ack_code == `ACK_BUSY_X) || (tx_ack_code == `ACK_BUSY_A) ||
            (tx_ack_code == `ACK_BUSY_B))
         begin
            if (state.tx_count < state.retry_limit)
            begin
               next_state.tx_retry = 1'b1;
               next_state.tx_count = state.tx_count + 4'h1;
            end
            else
            begin
               next_state.tx_give_up = 1'b1;
               next_state.tx_count = 4'h0;
            end
         end
         else
         begin
            next_state.tx_count = 4'h0;
         end
      end
   end

   // State register; the reset value holds the retry limit field.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= '0;
         state.retry_limit <= 4'(`CTRL_RESET >> `CTRL_RETRY_LSB);
         state.physical_range_limit <= `LIMIT_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Outputs straight from the state register.
   assign pready = state.pready;
   assign prdata = state.prdata;
   assign pslverr = state.pslverr;
   assign ack = state.ack;
   assign arq_head_go = state.arq_go;
   assign arq_head_drop = state.arq_drop;
   assign phys_head_go = state.phys_go;
   assign posted_fail_event = state.fail_event;
   assign tx_retry = state.tx_retry;
   assign tx_give_up = state.tx_give_up;

   // Checks on the acknowledge, the space count, the queue gates, failure capture and transmit retry.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_undef_drop: assert property (req_valid && !defined_tcode |=> !ack.valid &&
      ack.dest == async_request_ack_posting_pkg::dest_none) else $error("undefined code acked");
   chk_reg_pending: assert property (req_valid && defined_tcode && in_reg_space |=>
      ack.code == `ACK_PENDING) else $error("register space not pending");
   chk_upper_complete: assert property (req_valid && defined_tcode && is_write &&
      in_upper && !in_reg_space && !ext_block && !async_blocked && free_found |=>
      ack.code == `ACK_COMPLETE && ack.posted) else $error("upper write not completed");
   chk_nopost_pending: assert property (req_valid && below_limit && !state.post_enable |=>
      ack.code != `ACK_COMPLETE) else $error("complete while posting off");
   chk_full_no_post: assert property (req_valid && !free_found |=>
      !ack.posted && ack.code != `ACK_COMPLETE) else $error("complete with no record");
   chk_fail_zero: assert property (state.context_running && store_fail |=>
      state.dead && state.space == 15'h0000 ##1 state.space == 15'h0000)
      else $error("space not zeroed");
   chk_stopped_zero: assert property (!state.context_running |=>
      state.space == 15'h0000) else $error("space not cleared while stopped");
   chk_dead_drain: assert property (state.dead && state.context_running && arq_head_valid &&
      !arq_head_drop && !arq_head_go |=> arq_head_drop) else $error("dead queue stalls");
   chk_dead_no_go: assert property (state.dead |=> !arq_head_go)
      else $error("dead context request forwarded");
   chk_async_order: assert property (arq_head_go |-> !$past(phys_pending))
      else $error("async request passed posted write");
   chk_fail_capture: assert property (mem_done_valid && mem_done_error && done_rec.busy |=>
      posted_fail_event && state.fail_sticky &&
      state.posted_fail_offset_low == $past(done_rec.offset[31:0]))
      else $error("posted failure not recorded");
   chk_full_busy: assert property (req_valid && defined_tcode && req_fifo_full &&
      !below_limit && !in_reg_space && !ext_block |=>
      ack.code inside {`ACK_BUSY_X, `ACK_BUSY_A, `ACK_BUSY_B}) else $error("full not busied");
   chk_tx_retry: assert property (tx_ack_valid && tx_ack_code == `ACK_BUSY_X &&
      state.tx_count < state.retry_limit |=> tx_retry && !tx_give_up)
      else $error("busy transmit not retried");

   cov_posted_physical: cover property (ack.posted &&
      ack.dest == async_request_ack_posting_pkg::dest_physical);
   cov_posted_fail: cover property (posted_fail_event);
   cov_dead_drop: cover property (arq_head_drop);
   cov_tx_give_up: cover property (tx_give_up);

endmodule : async_request_ack_posting

`default_nettype wire

// file: async_request_ack_posting_map.svh
// Register offsets, field positions, reset values and codes of the request acceptance block.
`ifndef ASYNC_REQUEST_ACK_POSTING_MAP_SVH
`define ASYNC_REQUEST_ACK_POSTING_MAP_SVH

// Register byte offsets on the APB port.
`define REG_CONTROL 8'h00
`define REG_LIMIT_LOW 8'h04
`define REG_LIMIT_HIGH 8'h08
`define REG_STATUS 8'h0C
`define REG_FAIL_LOW 8'h10
`define REG_FAIL_HIGH 8'h14

// Control register fields.
`define CTRL_RUN_BIT 0
`define CTRL_POST_BIT 1
`define CTRL_DUAL_BIT 2
`define CTRL_RETRY_LSB 8
`define CTRL_RESET 32'h0000_0300

// Status register fields.
`define STAT_DEAD_BIT 0
`define STAT_FAIL_BIT 1
`define STAT_PEND_LSB 4
`define STAT_SPACE_LSB 16

// Address space boundaries.
`define LIMIT_RESET 48'h0000_0000_0000
`define UPPER_TOP 48'hFFFE_FFFF_FFFF
`define REG_SPACE_BASE 48'hFFFF_0000_0000

// Transaction codes of received requests.
`define TC_WRITE_QUAD 4'h0
`define TC_WRITE_BLOCK 4'h1
`define TC_READ_QUAD 4'h4
`define TC_READ_BLOCK 4'h5
`define TC_LOCK 4'h9
`define TC_PHY 4'hE

// Acknowledge codes.
`define ACK_COMPLETE 4'h1
`define ACK_PENDING 4'h2
`define ACK_BUSY_X 4'h4
`define ACK_BUSY_A 4'h5
`define ACK_BUSY_B 4'h6

// Number of posted-write error records.
`define POSTED_SLOTS 4

`endif

// file: async_request_ack_posting_pkg.sv
// Types shared by the request acceptance block and its posted-write record.
package async_request_ack_posting_pkg;

   // One incoming request header as seen by the link side.
   typedef struct packed {
      logic [3:0] tcode;
      logic [15:0] ext_tcode;
      logic [47:0] offset;
      logic [15:0] source_id;
      logic [14:0] quadlets;
   } request_type;

   // Where an accepted request goes.
   typedef enum logic [1:0] {
      dest_none,
      dest_physical,
      dest_async
   } dest_type;

   // Acknowledge decision for one request.
   typedef struct packed {
      logic valid;
      logic [3:0] code;
      dest_type dest;
      logic posted;
      logic [1:0] slot;
   } ack_type;

   // One posted-write error record.
   typedef struct packed {
      logic busy;
      logic physical;
      logic [15:0] node_id;
      logic [47:0] offset;
   } record_type;

endpackage : async_request_ack_posting_pkg

// file: posted_record.sv
// One posted-write error record slot, held from acceptance until memory completion.
`timescale 1ns/1ps
`default_nettype none

module posted_record
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Allocation of this slot.
   input wire logic alloc,
   input wire logic alloc_physical,
   input wire logic [15:0] alloc_node,
   input wire logic [47:0] alloc_offset,
   // Completion of the write held here.
   input wire logic done,
   // Record contents.
   output async_request_ack_posting_pkg::record_type rec
);

   async_request_ack_posting_pkg::record_type state;
   async_request_ack_posting_pkg::record_type next_state;

   // A new allocation wins over a completion in the same cycle so no write goes untracked.
   always_comb
   begin
      next_state = state;
      if (done)
      begin
         next_state.busy = 1'b0;
      end
      if (alloc)
      begin
         next_state.busy = 1'b1;
         next_state.physical = alloc_physical;
         next_state.node_id = alloc_node;
         next_state.offset = alloc_offset;
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign rec = state;

endmodule : posted_record

`default_nettype wire

// file: remote_node.sv
// Remote bus node model that issues request headers toward the block.
`timescale 1ns/1ps
`default_nettype none

module remote_node
(
   // Clock.
   input wire logic pclk,
   // Command from the bench.
   input wire logic send,
   input wire async_request_ack_posting_pkg::request_type hdr,
   // Request toward the block.
   output logic req_valid = 1'b0,
   output async_request_ack_posting_pkg::request_type req = '0
);
   // Between requests the header is inverted so stale fields never pass for a new request.
   always @(posedge pclk)
   begin
      req_valid <= send;
      req <= send ? hdr : ~req;
   end
endmodule : remote_node

`default_nettype wire

// file: tb_async_request_ack_posting.sv
// Self-checking bench for the request acceptance block.
`timescale 1ns/1ps
`default_nettype none
`include "async_request_ack_posting_map.svh"

module tb_async_request_ack_posting;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr, send = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdata;
   logic pready, pslverr, req_valid, req_fifo_full = 0, desc_len_valid = 0;
   logic store_quadlet = 0, store_fail = 0, arq_head_valid = 0, phys_head_valid = 0;
   logic arq_head_go, arq_head_drop, phys_head_go, mem_done_valid = 0, mem_done_error = 0;
   logic posted_fail_event, tx_ack_valid = 0, tx_retry, tx_give_up;
   logic [13:0] request_buffer_length = 14'h0010;
   logic [1:0] mem_done_slot = 0, slot0;
   logic [3:0] tx_ack_code = `ACK_BUSY_X, c1;
   async_request_ack_posting_pkg::request_type req, hdr = '0;
   async_request_ack_posting_pkg::ack_type ack;
   int n_mismatch = 0, tests_run = 0;

   async_request_ack_posting i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .req_valid, .req, .req_fifo_full, .ack,
      .desc_len_valid, .request_buffer_length, .store_quadlet, .store_fail, .arq_head_valid,
      .arq_head_go, .arq_head_drop, .phys_head_valid, .phys_head_go, .mem_done_valid,
      .mem_done_slot, .mem_done_error, .posted_fail_event, .tx_ack_valid, .tx_ack_code,
      .tx_retry, .tx_give_up);
   remote_node i_node (.pclk, .send, .hdr, .req_valid, .req);

   // Free-running bus clock.
   always #10 pclk = ~pclk;

   // Comparison, verdict and bus tasks.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         n_mismatch++;
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 8 && pready !== 1'b1; i++)
         @(posedge pclk);
      // A slave that never answers ends the run rather than hanging it.
      if (i == 8)
      begin
         n_mismatch++;
         give_verdict();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rq(input logic [3:0] tc, input logic [15:0] ext, input logic [47:0] off,
      input logic v, input logic [3:0] code, input logic full);
      @(posedge pclk);
      send <= 1'b1;
      req_fifo_full <= full;
      hdr <= '{tc, ext, off, 16'h00A5, 15'h0001};
      @(posedge pclk);
      send <= 1'b0;
      @(posedge pclk);
      #1;
      chk("ack valid", 32'(v), 32'(ack.valid));
      if (v && code != 4'hF)
         chk("ack code", 32'(code), 32'(ack.code));
   endtask : rq
   task automatic head(input logic ph, input logic go, input logic dr);
      @(posedge pclk);
      phys_head_valid <= ph;
      arq_head_valid <= !ph;
      @(posedge pclk);
      phys_head_valid <= 1'b0;
      arq_head_valid <= 1'b0;
      #1;
      chk("head go", 32'(go), 32'(ph ? phys_head_go : arq_head_go));
      chk("head drop", 32'(dr), 32'(arq_head_drop));
   endtask : head

   // Main sequence; each group of calls is one test.
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `REG_CONTROL, 0);
      chk("control reset", `CTRL_RESET, rdata);
      apb(0, 8'h18, 0);
      chk("unmapped err", 32'h1, 32'(rerr));
      apb(1, `REG_LIMIT_LOW, 32'h0000_1000);
      apb(1, `REG_CONTROL, 32'h0000_0303);
      @(posedge pclk);
      desc_len_valid <= 1'b1;
      @(posedge pclk);
      desc_len_valid <= 1'b0;
      store_quadlet <= 1'b1;
      @(posedge pclk);
      store_quadlet <= 1'b0;
      apb(0, `REG_STATUS, 0);
      chk("space", 32'h000F_0000, rdata);
      $display("test reset and space done");
      rq(4'h2, 0, 48'h10, 0, 0, 0);
      rq(`TC_WRITE_QUAD, 0, `REG_SPACE_BASE, 1, `ACK_PENDING, 0);
      rq(`TC_WRITE_BLOCK, 16'h0001, 48'h2000, 1, `ACK_PENDING, 0);
      rq(`TC_WRITE_QUAD, 0, 48'h10, 1, `ACK_COMPLETE, 0);
      slot0 = ack.slot;
      chk("ack posted", 32'h1, 32'(ack.posted));
      rq(`TC_WRITE_QUAD, 0, `UPPER_TOP, 1, `ACK_COMPLETE, 0);
      rq(`TC_WRITE_QUAD, 0, 48'h20, 1, `ACK_COMPLETE, 0);
      rq(`TC_WRITE_QUAD, 0, 48'h30, 1, `ACK_COMPLETE, 0);
      rq(`TC_WRITE_QUAD, 0, 48'h40, 1, `ACK_PENDING, 0);
      rq(`TC_WRITE_QUAD, 0, 48'hFFFE_0000_0000, 1, `ACK_BUSY_X, 0);
      rq(`TC_READ_QUAD, 0, 48'h2000, 1, `ACK_PENDING, 0);
      apb(0, `REG_STATUS, 0);
      chk("pending count", 32'h000F_0040, rdata);
      head(0, 0, 0);
      head(1, 1, 0);
      $display("test acknowledge codes done");
      @(posedge pclk);
      mem_done_valid <= 1'b1;
      mem_done_slot <= slot0;
      mem_done_error <= 1'b1;
      @(posedge pclk);
      mem_done_valid <= 1'b0;
      #1;
      chk("fail event", 32'h1, 32'(posted_fail_event));
      apb(0, `REG_FAIL_LOW, 0);
      chk("fail low", 32'h0000_0010, rdata);
      apb(0, `REG_FAIL_HIGH, 0);
      chk("fail high", 32'h00A5_0000, rdata);
      // Clean completions of the last two physical posts let the async head go.
      for (int k = 2; k < 4; k++)
      begin
         @(posedge pclk);
         mem_done_valid <= 1'b1;
         mem_done_slot <= 2'(k);
         mem_done_error <= 1'b0;
      end
      @(posedge pclk);
      mem_done_valid <= 1'b0;
      #1;
      chk("clean done", 32'h0, 32'(posted_fail_event));
      head(0, 1, 0);
      $display("test posted failure done");
      apb(1, `REG_CONTROL, 32'h0000_0301);
      rq(`TC_WRITE_QUAD, 0, 48'h50, 1, `ACK_PENDING, 0);
      chk("no post", 32'h0, 32'(ack.posted));
      apb(1, `REG_CONTROL, 32'h0000_0305);
      rq(`TC_WRITE_QUAD, 0, 48'hFFFE_0000_0000, 1, 4'hF, 1);
      c1 = ack.code;
      chk("dual first", 32'h1, 32'(c1 == `ACK_BUSY_A || c1 == `ACK_BUSY_B));
      rq(`TC_WRITE_QUAD, 0, 48'hFFFE_0000_0000, 1, c1 ^ 4'h3, 1);
      for (int k = 0; k < 4; k++)
         tx(k < 3, k == 3);
      $display("test posting off and retries done");
      apb(1, `REG_CONTROL, 32'h0000_0301);
      @(posedge pclk);
      store_fail <= 1'b1;
      @(posedge pclk);
      store_fail <= 1'b0;
      rq(`TC_WRITE_QUAD, 0, 48'hFFFE_0000_0000, 1, `ACK_BUSY_X, 0);
      head(0, 0, 1);
      apb(0, `REG_STATUS, 0);
      chk("dead status", 32'h0000_0013, rdata);
      $display("test dead context done");
      give_verdict();
   end

   // Transmit acknowledge with the retry outcome expected in the next cycle.
   task automatic tx(input logic r, input logic g);
      @(posedge pclk);
      tx_ack_valid <= 1'b1;
      @(posedge pclk);
      tx_ack_valid <= 1'b0;
      #1;
      chk("tx retry", 32'(r), 32'(tx_retry));
      chk("tx give up", 32'(g), 32'(tx_give_up));
   endtask : tx
endmodule : tb_async_request_ack_posting

`default_nettype wire
